// ---- src/tg_fifo.sv ----
`timescale 1ns/1ps
module tg_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	// fill side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// drain side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("tg_fifo depth must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wptr;
		logic [AW-1:0]           rptr;
		logic [AW:0]             count;
	} tg_fifo_s;

	tg_fifo_s s_q;
	tg_fifo_s s_d;
	logic     push;
	logic     pop;

	// flags straight from the fill count
	assign in_ready  = (s_q.count != (AW+1)'(DEPTH));
	assign out_valid = (s_q.count != '0);
	assign out_data  = s_q.mem[s_q.rptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer and count update
	always_comb
	begin
		s_d = s_q;
		if (push)
		begin
			s_d.mem[s_q.wptr] = in_data;
			s_d.wptr          = s_q.wptr + 1'b1;
		end
		if (pop)
			s_d.rptr = s_q.rptr + 1'b1;
		if (push && !pop)
			s_d.count = s_q.count + 1'b1;
		else if (pop && !push)
			s_d.count = s_q.count - 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule

// ---- src/tg_pkg.sv ----
package tg_pkg;
	// widths of the sample path and the register port
	localparam int SAMPLE_W = 16;
	localparam int STEP_W   = 16;
	localparam int REG_AW   = 4;
	localparam int REG_DW   = 8;

	// register offsets
	localparam logic [REG_AW-1:0] ADDR_A_LOW  = 4'h0;
	localparam logic [REG_AW-1:0] ADDR_A_HIGH = 4'h1;
	localparam logic [REG_AW-1:0] ADDR_B_LOW  = 4'h2;
	localparam logic [REG_AW-1:0] ADDR_B_HIGH = 4'h3;
	localparam logic [REG_AW-1:0] ADDR_SOURCE = 4'h4;
	localparam logic [REG_AW-1:0] ADDR_KEYPAD = 4'h5;
	localparam logic [REG_AW-1:0] ADDR_CYCLES = 4'h6;
	localparam logic [REG_AW-1:0] ADDR_ON_PER = 4'h7;
	localparam logic [REG_AW-1:0] ADDR_OFF_PER = 4'h8;
	localparam logic [REG_AW-1:0] ADDR_CTRL   = 4'h9;
	localparam logic [REG_AW-1:0] ADDR_STATUS = 4'hA;

	// field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_FAM_BIT   = 1;
	localparam int SRC_KP_BIT     = 2;
	localparam int STAT_RUN_BIT   = 0;
	localparam int STAT_ON_BIT    = 1;
	localparam int STAT_CNT_LSB   = 2;

	// source select codes and continuous beep codes
	localparam logic [1:0] SEL_A    = 2'h0;
	localparam logic [1:0] SEL_B    = 2'h1;
	localparam logic [1:0] SEL_BOTH = 2'h2;
	localparam logic [1:0] SEL_RAMP = 2'h3;
	localparam logic [2:0] CYC_CONT0 = 3'h6;
	localparam logic [2:0] CYC_CONT1 = 3'h7;
	localparam int BEEP_CNT_W = 6;

	// beep period base: 10 ms units, 200 units make 2 s
	localparam int CLK_PERIOD_NS      = 10;
	localparam int PERIOD_UNIT_NS     = 10_000_000;
	localparam int PERIOD_UNIT_CYCLES = PERIOD_UNIT_NS / CLK_PERIOD_NS;
	localparam logic [7:0] PERIOD_CODE_MAX = 8'hC7;

	// step scaling per rate family and keypad tones in hertz
	localparam int RATE_DIV_12K = 12000;
	localparam int RATE_DIV_11K = 11025;
	localparam int KP_LOW_HZ [4]  = '{697, 770, 852, 941};
	localparam int KP_HIGH_HZ [4] = '{1209, 1336, 1477, 1633};

	typedef enum logic [1:0] {TG_IDLE, TG_ON, TG_OFF} tg_state_e;

	// rounded step code: 2^16 * hz / div
	function automatic logic [STEP_W-1:0] tg_step_of(input int hz, input int div);
		return STEP_W'((65536 * hz * 2 + div) / (2 * div));
	endfunction

	// number of beeps per count code
	function automatic logic [BEEP_CNT_W-1:0] tg_beeps(input logic [2:0] code);
		case (code)
			3'h0: return 6'h01;
			3'h1: return 6'h02;
			3'h2: return 6'h03;
			3'h3: return 6'h04;
			3'h4: return 6'h08;
			3'h5: return 6'h10;
			default: return 6'h20;
		endcase
	endfunction
endpackage

// ---- src/tg_shape.sv ----
`timescale 1ns/1ps
module tg_shape (
	// phases of both sources
	input  wire logic [tg_pkg::STEP_W-1:0]   phase_a,
	input  wire logic [tg_pkg::STEP_W-1:0]   phase_b,
	// shape selection
	input  wire logic [1:0]                  sel,
	input  wire logic                        kp_en,
	// shaped sample
	output logic [tg_pkg::SAMPLE_W-1:0]      sample
);
	import tg_pkg::*;

	// parabolic sine: cheap, no table, peak 32766
	function automatic logic signed [SAMPLE_W-1:0] sine_of(input logic [STEP_W-1:0] p);
		logic [14:0] x;
		logic [29:0] prod;
		logic [14:0] mag;
		x    = p[14:0];
		prod = 30'(x) * 30'(15'h7FFF - x);
		mag  = prod[27:13];
		return p[15] ? -SAMPLE_W'(mag) : SAMPLE_W'(mag);
	endfunction

	// smoothstep on the upper phase bits of source a
	function automatic logic signed [SAMPLE_W-1:0] ramp_of(input logic [STEP_W-1:0] p);
		logic [25:0] y;
		y = 26'(p[15:8]) * 26'(p[15:8]) * (26'h300 - 26'({p[15:8], 1'b0}));
		return SAMPLE_W'(y[23:8]) ^ 16'h8000;
	endfunction

	logic signed [SAMPLE_W-1:0] sa;
	logic signed [SAMPLE_W-1:0] sb;
	logic signed [SAMPLE_W:0]   sum;

	assign sa  = sine_of(phase_a);
	assign sb  = sine_of(phase_b);
	assign sum = (SAMPLE_W+1)'(sa) + (SAMPLE_W+1)'(sb);

	// keypad tones always need both sources
	always_comb
	begin
		if (kp_en)
			sample = sum[SAMPLE_W:1];
		else
			case (sel)
				SEL_A:    sample = sa;
				SEL_B:    sample = sb;
				SEL_BOTH: sample = sum[SAMPLE_W:1];
				SEL_RAMP: sample = ramp_of(phase_a);
				default:  sample = '0;
			endcase
	end
endmodule

// ---- src/tg_top.sv ----
// Contract
// R01: two independent sine sources, each with its own step code
// R02: each source covers about 1 Hz to 12 kHz via a 16-bit step
// R03: 12 kHz rate family: step = 2^16 * f / 12000
// R04: 11.025 kHz rate family: step = 2^16 * f / 11025
// R05: software never programs a tone above half the sample rate
// R06: each step code is split into a high and a low byte
// R07: source select picks source a, source b or both combined
// R08: keypad enable makes both sources play the keypad tone pair
// R09: keypad code maps to one low row tone and one high column tone
// R10: beep count gives 1,2,3,4,8,16,32 beeps; 110 and 111 continuous (here no count code gives 32 beeps)
// R11: on and off periods each programmable from 10 ms to 2 s
// R12: setting start runs the generator, clearing it requests a halt
// R13: halt waits for end of beep cycle, or zero crossing if continuous
// R14: start bit clears itself after the programmed beeps are done
// R15: source select code 3 outputs an s-shaped ramp
// R16: in keypad mode the programmed step codes are ignored
// R17: one sample per rate strobe, phases advance by step each strobe (here a strobe that comes while another is pending is lost)
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module tg_top #(
	parameter int UNIT_CYCLES = tg_pkg::PERIOD_UNIT_CYCLES,
	parameter int FIFO_DEPTH  = 8
) (
	// clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          rst_b,
	// register port
	input  wire logic [tg_pkg::REG_AW-1:0]     reg_addr,
	input  wire logic [tg_pkg::REG_DW-1:0]     reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic [tg_pkg::REG_DW-1:0]          reg_rdata,
	// output sample rate strobe
	input  wire logic                          sample_stb,
	// samples to the mixer
	output logic                               mix_valid,
	output logic [tg_pkg::SAMPLE_W-1:0]        mix_data,
	input  wire logic                          mix_ready,
	// status
	output logic                               tone_active
);
	import tg_pkg::*;

	localparam int TW = $clog2(UNIT_CYCLES + 1);

	initial
	begin
		if (UNIT_CYCLES < 1)
			$error("tg_top needs at least one cycle per period unit");
	end

	typedef struct packed {
		logic [STEP_W-1:0]     step_a;
		logic [STEP_W-1:0]     step_b;
		logic [1:0]            sel;
		logic                  kp_en;
		logic [3:0]            kp_code;
		logic [2:0]            cycles;
		logic [7:0]            on_per;
		logic [7:0]            off_per;
		logic                  start;
		logic                  fam;
		tg_state_e             state;
		logic [STEP_W-1:0]     phase_a;
		logic [STEP_W-1:0]     phase_b;
		logic [TW-1:0]         tick_cnt;
		logic [7:0]            per_cnt;
		logic [BEEP_CNT_W-1:0] beep_cnt;
		logic                  pend;
		logic                  push;
		logic [SAMPLE_W-1:0]   sample;
		logic                  prev_sign;
		logic [REG_DW-1:0]     rdata;
		logic                  mix_valid;
		logic [SAMPLE_W-1:0]   mix_data;
		logic                  running;
	} tg_top_s;

	tg_top_s             s_q;
	tg_top_s             s_d;
	logic [STEP_W-1:0]   eff_a;
	logic [STEP_W-1:0]   eff_b;
	logic [SAMPLE_W-1:0] shaped;
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic [SAMPLE_W-1:0] fifo_out_data;
	logic                fifo_pop;
	logic                take;
	logic                tick;
	logic                per_end;
	logic                cont;
	logic                ctrl_wr;
	logic [7:0]          per_lim;

	// keypad row and column from the code
	function automatic logic [1:0] kp_row(input logic [3:0] c);
		case (c)
			4'h1, 4'h2, 4'h3, 4'hA: return 2'h0;
			4'h4, 4'h5, 4'h6, 4'hB: return 2'h1;
			4'h7, 4'h8, 4'h9, 4'hC: return 2'h2;
			default:                return 2'h3;
		endcase
	endfunction

	function automatic logic [1:0] kp_col(input logic [3:0] c);
		case (c)
			4'h1, 4'h4, 4'h7, 4'hE: return 2'h0;
			4'h2, 4'h5, 4'h8, 4'h0: return 2'h1;
			4'h3, 4'h6, 4'h9, 4'hF: return 2'h2;
			default:                return 2'h3;
		endcase
	endfunction

	// step for a keypad tone, scaled for the active rate family
	function automatic logic [STEP_W-1:0] kp_step(input int hz, input logic fam);
		return fam ? tg_step_of(hz, RATE_DIV_11K) : tg_step_of(hz, RATE_DIV_12K);
	endfunction

	// effective steps: keypad table overrides programmed codes
	always_comb
	begin
		if (s_q.kp_en)
		begin
			eff_a = kp_step(KP_HIGH_HZ[kp_col(s_q.kp_code)], s_q.fam); // see R09 see R03 see R04
			eff_b = kp_step(KP_LOW_HZ[kp_row(s_q.kp_code)], s_q.fam); // see R08 see R16
		end
		else
		begin
			eff_a = s_q.step_a; // see R01 see R02
			eff_b = s_q.step_b;
		end
	end

	tg_shape u_shape (
		.phase_a (s_q.phase_a),
		.phase_b (s_q.phase_b),
		.sel     (s_q.sel),
		.kp_en   (s_q.kp_en),
		.sample  (shaped)
	);

	// samples queue here so a stalled mixer stalls the generator
	tg_fifo #(
		.W     (SAMPLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.in_valid  (s_q.push),
		.in_data   (s_q.sample),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out_data),
		.out_ready (fifo_pop)
	);

	// pushes are one at a time, so ready seen here cannot go stale
	assign take     = (sample_stb || s_q.pend) && fifo_in_ready && !s_q.push;
	assign fifo_pop = fifo_out_valid && (!s_q.mix_valid || mix_ready);
	assign tick     = (s_q.tick_cnt == TW'(UNIT_CYCLES - 1));
	assign cont     = (s_q.cycles == CYC_CONT0) || (s_q.cycles == CYC_CONT1); // see R10
	assign per_lim  = (s_q.state == TG_ON) ? s_q.on_per : s_q.off_per;
	assign per_end  = tick && (s_q.per_cnt >= per_lim || s_q.per_cnt >= PERIOD_CODE_MAX); // see R11
	assign ctrl_wr  = reg_wr && (reg_addr == ADDR_CTRL);

	// register writes, beep sequencing and sample production
	always_comb
	begin
		s_d      = s_q;
		s_d.push = 1'b0;
		if (s_q.state != TG_IDLE)
			s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;
		if (tick)
			s_d.per_cnt = s_q.per_cnt + 1'b1;
		// beep sequencer
		case (s_q.state)
			TG_IDLE:
			begin
				if (s_q.start) // see R12
				begin
					s_d.state    = TG_ON;
					s_d.phase_a  = '0;
					s_d.phase_b  = '0;
					s_d.tick_cnt = '0;
					s_d.per_cnt  = '0;
					s_d.beep_cnt = '0;
				end
			end
			TG_ON:
			begin
				if (per_end)
				begin
					s_d.state    = TG_OFF;
					s_d.tick_cnt = '0;
					s_d.per_cnt  = '0;
				end
			end
			TG_OFF:
			begin
				if (per_end)
				begin
					s_d.tick_cnt = '0;
					s_d.per_cnt  = '0;
					s_d.beep_cnt = s_q.beep_cnt + 1'b1;
					if (!s_q.start && !cont)
						s_d.state = TG_IDLE; // see R13
					else if (!cont && (s_q.beep_cnt + 1'b1) >= tg_beeps(s_q.cycles))
					begin
						s_d.state = TG_IDLE;
						s_d.start = 1'b0; // see R14
					end
					else
						s_d.state = TG_ON;
				end
			end
			default: s_d.state = TG_IDLE;
		endcase
		// sample per strobe; off period and idle give silence
		s_d.pend = (sample_stb || s_q.pend) && !take;
		if (take)
		begin
			s_d.phase_a   = s_q.phase_a + eff_a; // see R17
			s_d.phase_b   = s_q.phase_b + eff_b;
			s_d.push      = 1'b1;
			s_d.sample    = (s_q.state == TG_ON) ? shaped : '0; // see R07 see R15
			s_d.prev_sign = shaped[SAMPLE_W-1];
			if (cont && !s_q.start && s_q.state != TG_IDLE
				&& shaped[SAMPLE_W-1] != s_q.prev_sign)
			begin
				s_d.state  = TG_IDLE; // see R13
				s_d.sample = '0;
			end
		end
		// software writes; a start written here wins over the self clear
		if (reg_wr)
			case (reg_addr)
				ADDR_A_LOW:   s_d.step_a[7:0]  = reg_wdata; // see R06
				ADDR_A_HIGH:  s_d.step_a[15:8] = reg_wdata;
				ADDR_B_LOW:   s_d.step_b[7:0]  = reg_wdata;
				ADDR_B_HIGH:  s_d.step_b[15:8] = reg_wdata;
				ADDR_SOURCE:
				begin
					s_d.sel   = reg_wdata[1:0];
					s_d.kp_en = reg_wdata[SRC_KP_BIT];
				end
				ADDR_KEYPAD:  s_d.kp_code = reg_wdata[3:0];
				ADDR_CYCLES:  s_d.cycles  = reg_wdata[2:0];
				ADDR_ON_PER:  s_d.on_per  = reg_wdata;
				ADDR_OFF_PER: s_d.off_per = reg_wdata;
				ADDR_CTRL:
				begin
					s_d.start = reg_wdata[CTRL_START_BIT]; // see R12
					s_d.fam   = reg_wdata[CTRL_FAM_BIT];
				end
				default: ;
			endcase
		// read data stands only in the cycle after the strobe
		s_d.rdata = '0;
		if (reg_rd)
			case (reg_addr)
				ADDR_A_LOW:   s_d.rdata = s_q.step_a[7:0];
				ADDR_A_HIGH:  s_d.rdata = s_q.step_a[15:8];
				ADDR_B_LOW:   s_d.rdata = s_q.step_b[7:0];
				ADDR_B_HIGH:  s_d.rdata = s_q.step_b[15:8];
				ADDR_SOURCE:  s_d.rdata = {5'h00, s_q.kp_en, s_q.sel};
				ADDR_KEYPAD:  s_d.rdata = {4'h0, s_q.kp_code};
				ADDR_CYCLES:  s_d.rdata = {5'h00, s_q.cycles};
				ADDR_ON_PER:  s_d.rdata = s_q.on_per;
				ADDR_OFF_PER: s_d.rdata = s_q.off_per;
				ADDR_CTRL:    s_d.rdata = {6'h00, s_q.fam, s_q.start};
				ADDR_STATUS:  s_d.rdata = {s_q.beep_cnt, s_q.state == TG_ON,
						s_q.state != TG_IDLE};
				default:      s_d.rdata = '0;
			endcase
		// output register toward the mixer
		if (fifo_pop)
		begin
			s_d.mix_valid = 1'b1;
			s_d.mix_data  = fifo_out_data;
		end
		else if (mix_ready)
			s_d.mix_valid = 1'b0;
		s_d.running = (s_d.state != TG_IDLE);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			s_q       <= '0;
			s_q.state <= TG_IDLE;
		end
		else
			s_q <= s_d;
	end

	assign reg_rdata   = s_q.rdata;
	assign mix_valid   = s_q.mix_valid;
	assign mix_data    = s_q.mix_data;
	assign tone_active = s_q.running;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	AST_START_RUNS: assert property ( // see R12
		s_q.state == TG_IDLE && s_q.start |=> s_q.state == TG_ON && s_q.beep_cnt == '0)
		else $error("start did not launch a beep");
	AST_SELF_CLEAR: assert property ( // see R14
		s_q.state == TG_OFF && per_end && s_q.start && !cont && !ctrl_wr
		&& (s_q.beep_cnt + 1'b1) >= tg_beeps(s_q.cycles) |=> !s_q.start && s_q.state == TG_IDLE)
		else $error("start bit not cleared after last beep");
	AST_STEP_BYTES: assert property ( // see R06
		reg_wr && reg_addr == ADDR_B_HIGH |=> s_q.step_b[15:8] == $past(reg_wdata)
		&& s_q.step_b[7:0] == $past(s_q.step_b[7:0]))
		else $error("step high byte not stored alone");
	AST_PHASE_STEP: assert property ( // see R17
		take |=> s_q.push && s_q.phase_a == $past(s_q.phase_a) + $past(eff_a)
		&& s_q.phase_b == $past(s_q.phase_b) + $past(eff_b))
		else $error("phase did not advance by step");
	AST_KEYPAD_STEP: assert property ( // see R16
		s_q.kp_en && s_q.kp_code == 4'h5 && !s_q.fam |-> eff_a == 16'h1C80 && eff_b == 16'h106D)
		else $error("keypad step wrong");
	AST_PROGRAMMED: assert property ( // see R01
		!s_q.kp_en |-> eff_a == s_q.step_a && eff_b == s_q.step_b)
		else $error("programmed step not used");
	AST_HALT_CYCLE: assert property ( // see R13
		s_q.state == TG_ON && !s_q.start && !cont |=> s_q.state != TG_IDLE)
		else $error("halt cut a beep short");
	AST_CONT_KEEP: assert property ( // see R10
		cont && s_q.start && s_q.state == TG_OFF && per_end && !ctrl_wr
		|=> s_q.state == TG_ON && s_q.start)
		else $error("continuous beep stopped");
	AST_OFF_SILENT: assert property ( // see R11
		take && s_q.state == TG_OFF |=> s_q.sample == '0 ##1 !s_q.push)
		else $error("sound during off period");
	AST_READ_ONCE: assert property (
		reg_rd && reg_addr == ADDR_CTRL ##1 !reg_rd |=> s_q.rdata == '0)
		else $error("read data held too long");
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
	import tg_pkg::*;
	// keypad code to row and column index
	localparam int KP_ROW [16] = '{3, 0, 0, 0, 1, 1, 1, 2, 2, 2, 0, 1, 2, 3, 3, 3};
	localparam int KP_COL [16] = '{1, 0, 1, 2, 0, 1, 2, 0, 1, 2, 3, 3, 3, 3, 0, 2};
	logic        ref_clk, rst_b, reg_wr, reg_rd, sample_stb;
	logic        mix_valid, mix_ready, tone_active;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [15:0] mix_data;
	logic [1:0]  pace;
	logic [15:0] q [$];
	logic [15:0] res [6];
	logic [15:0] ref_s [6];
	int          err_total, n_tests, cyc, act_n;

	tg_top #(.UNIT_CYCLES(4), .FIFO_DEPTH(8)) dut_u (
		.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_stb(sample_stb),
		.mix_valid(mix_valid), .mix_data(mix_data), .mix_ready(mix_ready),
		.tone_active(tone_active));
	tg_mix_model mdl_u (.ref_clk(ref_clk), .rst_b(rst_b), .pace(pace), .mix_ready(mix_ready));

	// clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// active time, taken samples and hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (tone_active === 1'b1) act_n++;
		if (mix_valid === 1'b1 && mix_ready === 1'b1) q.push_back(mix_data);
		if (cyc == 30000)
		begin
			err_total++;
			print_verdict();
		end
	end

	task print_verdict();
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// whole sample run equal (or not) to the reference run
	task cmp(input string nm, input bit eq);
		bit hit;
		hit = 1'b1;
		for (int i = 0; i < 6; i++) if (res[i] !== ref_s[i]) hit = 1'b0;
		n_tests++;
		if (hit != eq)
		begin
			err_total++;
			$display("Error %s expected %0d seen %0d", nm, eq, hit);
		end
	endtask

	// bus cycles leave one idle cycle so no strobe is driven twice per step
	task wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask

	task rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(nm, {8'h00, e}, {8'h00, reg_rdata});
		@(posedge ref_clk);
	endtask

	task stb(input int n);
		repeat (n)
		begin
			sample_stb <= 1'b1;
			@(posedge ref_clk);
			sample_stb <= 1'b0;
			@(posedge ref_clk);
		end
	endtask

	task set_steps(input logic [15:0] a, input logic [15:0] b);
		wr(ADDR_A_LOW, a[7:0]);
		wr(ADDR_A_HIGH, a[15:8]);
		wr(ADDR_B_LOW, b[7:0]);
		wr(ADDR_B_HIGH, b[15:8]);
	endtask

	task wait_on();
		for (int k = 0; k < 10 && tone_active !== 1'b1; k++) @(posedge ref_clk);
	endtask

	task wait_off();
		for (int k = 0; k < 2000 && tone_active !== 1'b0; k++) @(posedge ref_clk);
		chk("tone_active_idle", 16'h0, {15'h0, tone_active});
	endtask

	// rounded step code per rate family
	function automatic logic [15:0] stp(input int hz, input bit fam);
		int dv;
		dv = fam ? 11025 : 12000;
		return 16'((65536 * hz + dv / 2) / dv);
	endfunction

	// one beep, six strobes, samples kept in res
	task run_tone(input logic [1:0] sel, input bit kp, input logic [3:0] code, input bit fam);
		wr(ADDR_SOURCE, {5'h00, kp, sel});
		wr(ADDR_KEYPAD, {4'h0, code});
		wr(ADDR_CYCLES, 8'h00);
		wr(ADDR_ON_PER, 8'h07);
		wr(ADDR_OFF_PER, 8'h00);
		wr(ADDR_CTRL, {6'h00, fam, 1'b1});
		wait_on();
		q.delete();
		stb(6);
		// a slow mixer may take the last sample nine cycles on; stay clear of that edge
		repeat (12) @(posedge ref_clk);
		chk("sample_count", 16'd6, 16'(q.size()));
		for (int i = 0; i < 6; i++) res[i] = (i < q.size()) ? q[i] : 16'h0;
		wait_off();
	endtask

	task t_regs();
		for (int a = 0; a < 16; a++) rchk("reset_reg", a[3:0], 8'h00);
		wr(ADDR_A_LOW, 8'h5A);
		wr(ADDR_A_HIGH, 8'hC3);
		rchk("a_low", ADDR_A_LOW, 8'h5A);
		rchk("a_high", ADDR_A_HIGH, 8'hC3);
		wr(4'hF, 8'hFF);
		rchk("unmapped", 4'hF, 8'h00);
		wr(ADDR_STATUS, 8'hFF);
		rchk("status_ro", ADDR_STATUS, 8'h00);
	endtask

	// steps stay well under half the rate
	task t_sel();
		ref_s = '{default: 16'h0};
		set_steps(16'h0800, 16'h0800);
		run_tone(SEL_A, 1'b0, 4'h0, 1'b0);
		cmp("tone_silent", 1'b0);
		ref_s = res;
		set_steps(16'h0800, 16'h2000);
		run_tone(SEL_A, 1'b0, 4'h0, 1'b0);
		cmp("sel_a", 1'b1);
		set_steps(16'h2000, 16'h0800);
		run_tone(SEL_B, 1'b0, 4'h0, 1'b0);
		cmp("sel_b", 1'b1);
		set_steps(16'h0800, 16'h0800);
		run_tone(SEL_BOTH, 1'b0, 4'h0, 1'b0);
		cmp("sel_both", 1'b1);
		// unequal tones: the combined output must differ from source a alone
		set_steps(16'h0800, 16'h2000);
		run_tone(SEL_BOTH, 1'b0, 4'h0, 1'b0);
		cmp("sel_both_mix", 1'b0);
		run_tone(SEL_RAMP, 1'b0, 4'h0, 1'b0);
		cmp("sel_ramp", 1'b0);
	endtask

	// keypad pair against the same pair programmed by hand, slow mixer on odd codes
	task t_keypad();
		for (int f = 0; f < 2; f++)
			for (int c = 0; c < 16; c++)
			begin
				pace <= c[0] ? 2'h1 : 2'h0;
				set_steps(16'h0123, 16'h0456);
				run_tone(SEL_A, 1'b1, c[3:0], f[0]);
				ref_s = res;
				pace <= 2'h0;
				set_steps(stp(KP_HIGH_HZ[KP_COL[c]], f[0]), stp(KP_LOW_HZ[KP_ROW[c]], f[0]));
				run_tone(SEL_BOTH, 1'b0, 4'h0, f[0]);
				cmp("keypad", 1'b1);
			end
	endtask

	// counted beeps: duration n * (on + off + 2) units with period codes capped at 8'hC7, start bit clears itself
	task t_beeps();
		logic [7:0] cy [7];
		logic [7:0] on [7];
		logic [7:0] off [7];
		int         exp_n [7];
		cy = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h00};
		on = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'hC7};
		off = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
		exp_n = '{12, 24, 36, 48, 96, 192, 1600};
		for (int i = 0; i < 7; i++)
		begin
			wr(ADDR_CYCLES, cy[i]);
			wr(ADDR_ON_PER, on[i]);
			wr(ADDR_OFF_PER, off[i]);
			act_n = 0;
			wr(ADDR_CTRL, 8'h01);
			wait_on();
			wait_off();
			chk("beep_time", 16'(exp_n[i]), 16'(act_n));
			rchk("self_clear", ADDR_CTRL, 8'h00);
		end
	endtask

	// clear in the first beep: only that beep cycle completes
	task t_halt();
		wr(ADDR_CYCLES, 8'h03);
		wr(ADDR_ON_PER, 8'h01);
		wr(ADDR_OFF_PER, 8'h00);
		act_n = 0;
		wr(ADDR_CTRL, 8'h01);
		wr(ADDR_CTRL, 8'h00);
		// still in the first on period: beeps done 0, on bit and running bit set
		rchk("status_on", ADDR_STATUS, 8'h03);
		wait_off();
		chk("halt_time", 16'd12, 16'(act_n));
	endtask

	// continuous codes run on, then stop at a sign change once cleared
	task t_cont();
		set_steps(16'h1000, 16'h0000);
		wr(ADDR_SOURCE, {6'h00, SEL_A});
		wr(ADDR_ON_PER, 8'h00);
		wr(ADDR_OFF_PER, 8'h00);
		for (int c = 6; c < 8; c++)
		begin
			wr(ADDR_CYCLES, 8'(c));
			wr(ADDR_CTRL, 8'h01);
			stb(30);
			rchk("cont_running", ADDR_CTRL, 8'h01);
			wr(ADDR_CTRL, 8'h00);
			for (int k = 0; k < 40 && tone_active !== 1'b0; k++) stb(1);
			chk("cont_stop", 16'h0, {15'h0, tone_active});
		end
	endtask

	// stalled mixer: buffer fills, holds, then drains in full
	task t_fifo();
		pace <= 2'h2;
		wr(ADDR_CYCLES, 8'h00);
		wr(ADDR_ON_PER, 8'hC7);
		wr(ADDR_CTRL, 8'h01);
		wait_on();
		q.delete();
		stb(12);
		chk("stall_taken", 16'h0, 16'(q.size()));
		chk("stall_valid", 16'h1, {15'h0, mix_valid});
		pace <= 2'h0;
		repeat (12) @(posedge ref_clk);
		// output register, eight queued words and the one pending strobe
		chk("drained", 16'd10, 16'(q.size()));
		wr(ADDR_CTRL, 8'h00);
		wait_off();
	endtask

	// reset, then every scenario in turn
	initial
	begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		sample_stb = 1'b0;
		pace = 2'h0;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_sel();
		t_keypad();
		t_beeps();
		t_halt();
		t_cont();
		t_fifo();
		print_verdict();
	end
endmodule

// ---- verif/tg_mix_model.sv ----
`timescale 1ns/1ps
module tg_mix_model (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// pacing: 0 prompt, 1 slow, 2 stalled
	input  wire logic [1:0] pace,
	// sample handshake
	output logic            mix_ready
);
	logic [1:0] ph_q;

	// slow pace takes one sample in three cycles, so the queue backs up
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			ph_q <= 2'h0;
		else
			ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
	end

	// stalled pace never takes, to fill the buffer
	assign mix_ready = (pace == 2'h0) || (pace == 2'h1 && ph_q == 2'h0);
endmodule
